// *** logic/adc_host.sv ***
// Host-side sequencer for an asynchronous page-mode DRAM
module adc_host
  import adc_pkg::*;
#(
  parameter bit FAST_GRADE     = 1'b1,
  parameter bit LOW_POWER      = 1'b0,
  parameter int INIT_CYCLES    = INIT_CYC
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                srst,
  // User request
  input  wire logic                req_valid,
  input  wire logic                req_write,
  input  wire logic [2*ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0]   req_wdata,
  output logic                     req_ready,
  // User response
  output logic                     rsp_valid,
  output logic [DATA_W-1:0]        rsp_rdata,
  output logic                     init_done,
  // Memory pins
  output logic                     row_strobe_n,
  output logic                     col_strobe_n,
  output logic                     write_strobe_n,
  output logic                     out_enable_n,
  output logic [ADDR_W-1:0]        muxed_addr_pins,
  output logic [DATA_W-1:0]        data_pins_out,
  output logic                     data_pins_oe_n,
  input  wire logic [DATA_W-1:0]   data_pins_in
);

  // ----------------------------------------------------------------
  // Grade-dependent cycle counts, refresh interval set by LOW_POWER
  // ----------------------------------------------------------------
  localparam int RC_CYC  = cyc_min(FAST_GRADE ? T_RC_F_NS : T_RC_S_NS);
  localparam int RP_CYC  = cyc_min(FAST_GRADE ? T_RP_F_NS : T_RP_S_NS);
  localparam int RAS_CYC = cyc_min(FAST_GRADE ? T_RAS_F_NS : T_RAS_S_NS);
  localparam int REF_CYC = LOW_POWER ? REF_LP_CYC : REF_STD_CYC;
  localparam int HOLD_CYC = (CHR_CYC > RAS_CYC) ? CHR_CYC : RAS_CYC;
  // Column-low exit count, clamped so a short row minimum cannot wrap the 8-bit compare
  localparam int CAS_LOW  = (CAC_CYC > DH_CYC) ? CAC_CYC : DH_CYC;
  localparam int CAS_MIN  = (RAS_CYC - 2 > CAS_LOW) ? RAS_CYC - 3 : CAS_LOW - 1;

  adc_tmr_if tmr ();

  adc_timer #(
    .INIT_CYCLES    (INIT_CYCLES),
    .REFRESH_CYCLES (REF_CYC)
  ) u_timer (
    .ref_clk (ref_clk),
    .srst    (srst),
    .tmr     (tmr.timer)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  adc_state_t          st_q,    st_d;
  logic [7:0]          cnt_q,   cnt_d;
  logic [3:0]          wake_q,  wake_d;
  logic                wr_q,    wr_d;
  logic [2*ADDR_W-1:0] adr_q,   adr_d;
  logic                ras_q,   ras_d;
  logic                cas_q,   cas_d;
  logic                we_q,    we_d;
  logic                oe_q,    oe_d;
  logic [ADDR_W-1:0]   pa_q,    pa_d;
  logic [DATA_W-1:0]   dqo_q,   dqo_d;
  logic                dqe_q,   dqe_d;
  logic                rdy_q,   rdy_d;
  logic                rv_q,    rv_d;
  logic [DATA_W-1:0]   rd_q,    rd_d;
  logic                done_q,  done_d;
  logic                ack;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q + 8'h01;
    wake_d = wake_q;
    wr_d   = wr_q;
    adr_d  = adr_q;
    ras_d  = ras_q;
    cas_d  = cas_q;
    we_d   = we_q;
    oe_d   = oe_q;
    pa_d   = pa_q;
    dqo_d  = dqo_q;
    dqe_d  = dqe_q;
    rv_d   = 1'b0;
    rd_d   = rd_q;
    done_d = done_q;
    ack    = 1'b0;
    case (st_q)
      ST_PAUSE: begin
        cnt_d = 8'h00;
        if (tmr.pause_done) begin
          st_d  = ST_WAKE_LO;
          ras_d = 1'b0;
        end
      end
      ST_WAKE_LO: begin
        if (cnt_q >= 8'(RAS_CYC - 1)) begin
          st_d   = ST_WAKE_HI;
          ras_d  = 1'b1;
          cnt_d  = 8'h00;
          wake_d = wake_q + 4'h1;
        end
      end
      ST_WAKE_HI: begin
        if (cnt_q >= 8'(RC_CYC - RAS_CYC - 1) && cnt_q >= 8'(RP_CYC - 1)) begin
          cnt_d = 8'h00;
          if (wake_q == 4'(WAKE_COUNT)) begin
            st_d   = ST_IDLE;
            done_d = 1'b1;
          end else begin
            st_d  = ST_WAKE_LO;
            ras_d = 1'b0;
          end
        end
      end
      ST_IDLE: begin
        cnt_d = 8'h00;
        if (req_valid && rdy_q) begin
          st_d  = ST_ROW_SET;
          wr_d  = req_write;
          adr_d = req_addr;
          dqo_d = req_wdata;
          pa_d  = req_addr[2*ADDR_W-1:ADDR_W];
        end else if (tmr.refresh_req) begin
          // Refresh between accesses keeps the part from ever idling long
          st_d  = ST_REF_CAS;
          cas_d = 1'b0;
        end
      end
      ST_ROW_SET: begin
        st_d  = ST_ROW;
        ras_d = 1'b0;
      end
      ST_ROW: begin
        // Column address a full cycle after the row strobe
        st_d  = ST_COL;
        pa_d  = adr_q[ADDR_W-1:0];
        we_d  = ~wr_q;
        oe_d  = wr_q;
        dqe_d = ~wr_q;
        cnt_d = 8'h00;
      end
      ST_COL: begin
        if (cnt_q >= 8'(RCD_CYC - 1)) begin
          st_d  = ST_CAS;
          cas_d = 1'b0;
          cnt_d = 8'h00;
        end
      end
      ST_CAS: begin
        if (cnt_q >= 8'(CAS_MIN)) begin
          st_d  = ST_PRE;
          cas_d = 1'b1;
          ras_d = 1'b1;
          oe_d  = 1'b1;
          dqe_d = 1'b1;
          we_d  = 1'b1;
          cnt_d = 8'h00;
          if (!wr_q) begin
            rv_d = 1'b1;
            rd_d = data_pins_in;
          end
        end
      end
      ST_PRE: begin
        if (cnt_q >= 8'(RP_CYC - 1) && cnt_q >= 8'(RC_CYC - 2)) begin
          st_d  = ST_IDLE;
          cnt_d = 8'h00;
        end
      end
      ST_REF_CAS: begin
        if (cnt_q >= 8'(CSR_CYC - 1)) begin
          st_d  = ST_REF_RAS;
          ras_d = 1'b0;
          cnt_d = 8'h00;
        end
      end
      ST_REF_RAS: begin
        if (cnt_q >= 8'(HOLD_CYC - 1)) begin
          st_d  = ST_PRE;
          ras_d = 1'b1;
          cas_d = 1'b1;
          ack   = 1'b1;
          cnt_d = 8'h00;
        end
      end
      default: begin
        st_d = ST_PAUSE;
      end
    endcase
    // A pending refresh keeps ready low, so back-to-back requests cannot starve it
    rdy_d = (st_d == ST_IDLE) && done_d && !tmr.refresh_req;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q   <= ST_PAUSE;
      cnt_q  <= 8'h00;
      wake_q <= 4'h0;
      wr_q   <= 1'b0;
      adr_q  <= '0;
      ras_q  <= 1'b1;
      cas_q  <= 1'b1;
      we_q   <= 1'b1;
      oe_q   <= 1'b1;
      pa_q   <= '0;
      dqo_q  <= '0;
      dqe_q  <= 1'b1;
      rdy_q  <= 1'b0;
      rv_q   <= 1'b0;
      rd_q   <= '0;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      wake_q <= wake_d;
      wr_q   <= wr_d;
      adr_q  <= adr_d;
      ras_q  <= ras_d;
      cas_q  <= cas_d;
      we_q   <= we_d;
      oe_q   <= oe_d;
      pa_q   <= pa_d;
      dqo_q  <= dqo_d;
      dqe_q  <= dqe_d;
      rdy_q  <= rdy_d;
      rv_q   <= rv_d;
      rd_q   <= rd_d;
      done_q <= done_d;
    end
  end

  assign tmr.refresh_ack  = ack;
  assign req_ready        = rdy_q;
  assign rsp_valid        = rv_q;
  assign rsp_rdata        = rd_q;
  assign init_done        = done_q;
  assign row_strobe_n     = ras_q;
  assign col_strobe_n     = cas_q;
  assign write_strobe_n   = we_q;
  assign out_enable_n     = oe_q;
  assign muxed_addr_pins  = pa_q;
  assign data_pins_out    = dqo_q;
  assign data_pins_oe_n   = dqe_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [15:0] since_fall_q;
  logic [15:0] low_q;

  always_ff @(posedge ref_clk) begin
    if (srst || (ras_q && !ras_d)) begin
      since_fall_q <= 16'h0000;
    end else if (since_fall_q != 16'hFFFF) begin
      since_fall_q <= since_fall_q + 16'h0001;
    end
    low_q <= (srst || ras_q) ? 16'h0000 : low_q + 16'h0001;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_cas_after_ras: assert property ($fell(cas_q) && !ras_q |-> $past(!ras_q, 2))
    else $error("column strobe fell too soon after row strobe");
  a_cbr_setup: assert property ($fell(ras_q) && !cas_q |-> $past(!cas_q))
    else $error("refresh column strobe setup missed");
  a_early_write: assert property ($fell(cas_q) && !we_q |-> $past(!we_q))
    else $error("write strobe not ahead of column strobe");
  a_read_we_hold: assert property ($fell(cas_q) && we_q |-> we_q until_with $rose(cas_q))
    else $error("write strobe dropped during read");
  a_ras_spacing: assert property ($fell(ras_q) |-> $past(since_fall_q) >= 16'(RC_CYC - 1))
    else $error("row strobe falls too close together");
  a_ras_width: assert property (low_q < 16'(RAS_MAX_CYC))
    else $error("row strobe held low too long");
  a_init_seq: assert property ($rose(done_q) |-> wake_q == 4'(WAKE_COUNT) && cas_q)
    else $error("accesses enabled before wake cycles");
  a_read_sample: assert property (rv_q |-> $past(we_q) && $past(!oe_q))
    else $error("data sampled outside a clean read");
  a_data_hold: assert property (!cas_q && !dqe_q |=> $stable(dqo_q))
    else $error("write data changed while column strobe low");
  a_refresh_served: assert property ($rose(tmr.refresh_req) |-> ##[1:12] ack)
    else $error("refresh request not served in time");

endmodule // adc_host

// *** logic/adc_pkg.sv ***
// Package: timing figures, state codes and conversions for the page-mode DRAM host
package adc_pkg;

  // ----------------------------------------------------------------
  // Clock and geometry
  // ----------------------------------------------------------------
  localparam int CLK_NS     = 100;
  localparam int ADDR_W     = 9;
  localparam int DATA_W     = 4;
  localparam int WAKE_COUNT = 8;
  localparam int ROW_COUNT  = 512;
  localparam int INIT_US    = 200;

  // ----------------------------------------------------------------
  // Timing figures in ns (refresh periods in ms), fast grade then slow grade
  // ----------------------------------------------------------------
  localparam int T_RC_F_NS      = 110;
  localparam int T_RC_S_NS      = 150;
  localparam int T_RP_F_NS      = 40;
  localparam int T_RP_S_NS      = 60;
  localparam int T_RAS_F_NS     = 60;
  localparam int T_RAS_S_NS     = 80;
  localparam int T_RAS_MAX_NS   = 10000;
  localparam int T_RCD_NS       = 20;
  localparam int T_CSR_NS       = 5;
  localparam int T_CHR_NS       = 15;
  localparam int T_CAC_NS       = 20;
  localparam int T_DH_NS        = 15;
  localparam int REFRESH_STD_MS = 8;
  localparam int REFRESH_LP_MS  = 64;

  // Minimums round up, maximums round down, never below one cycle
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_max(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int INIT_CYC       = cyc_min(INIT_US * 1000);
  localparam int REF_STD_CYC    = cyc_max(REFRESH_STD_MS * 1000000 / ROW_COUNT);
  localparam int REF_LP_CYC     = cyc_max(REFRESH_LP_MS * 1000000 / ROW_COUNT);
  localparam int RAS_MAX_CYC    = cyc_max(T_RAS_MAX_NS);
  localparam int RCD_CYC        = cyc_min(T_RCD_NS);
  localparam int CSR_CYC        = cyc_min(T_CSR_NS);
  localparam int CHR_CYC        = cyc_min(T_CHR_NS);
  localparam int CAC_CYC        = cyc_min(T_CAC_NS);
  localparam int DH_CYC         = cyc_min(T_DH_NS);

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_PAUSE   = 4'h0,
    ST_WAKE_LO = 4'h1,
    ST_WAKE_HI = 4'h2,
    ST_IDLE    = 4'h3,
    ST_ROW_SET = 4'h4,
    ST_ROW     = 4'h5,
    ST_COL     = 4'h6,
    ST_CAS     = 4'h7,
    ST_PRE     = 4'h8,
    ST_REF_CAS = 4'h9,
    ST_REF_RAS = 4'hA
  } adc_state_t;

endpackage

// *** logic/adc_tmr_if.sv ***
// Interface: pause and refresh timing between timer and sequencer
interface adc_tmr_if;
  logic pause_done;
  logic refresh_req;
  logic refresh_ack;

  modport timer (output pause_done, output refresh_req, input refresh_ack);
  modport seq   (input pause_done, input refresh_req, output refresh_ack);
endinterface

// *** logic/adc_timer.sv ***
// Power-up pause and periodic refresh request timer
module adc_timer
  import adc_pkg::*;
#(
  parameter int INIT_CYCLES    = INIT_CYC,
  parameter int REFRESH_CYCLES = REF_STD_CYC
) (
  // Clock and reset
  input  wire logic  ref_clk,
  input  wire logic  srst,
  // Sequencer side
  adc_tmr_if.timer   tmr
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        done_q;
  logic        done_d;
  logic        req_q;
  logic        req_d;
  logic        tick;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d  = cnt_q + 16'h0001;
    done_d = done_q;
    tick   = 1'b0;
    if (!done_q && cnt_q == 16'(INIT_CYCLES - 1)) begin
      done_d = 1'b1;
      cnt_d  = 16'h0000;
    end else if (done_q && cnt_q == 16'(REFRESH_CYCLES - 1)) begin
      tick  = 1'b1;
      cnt_d = 16'h0000;
    end
    // A tick in the ack cycle is kept, set beats clear
    req_d = tick | (req_q & ~tmr.refresh_ack);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_q  <= 16'h0000;
      done_q <= 1'b0;
      req_q  <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
      req_q  <= req_d;
    end
  end

  assign tmr.pause_done  = done_q;
  assign tmr.refresh_req = req_q;

endmodule // adc_timer

// *** testbench/adc_dram_model.sv ***
// Behavioural page-mode DRAM that answers the host strobes and watches their timing
module adc_dram_model
  import adc_pkg::*;
#(
  parameter int RC_NS = T_RC_F_NS
) (
  // Host strobes and address
  input  wire logic              row_strobe_n,
  input  wire logic              col_strobe_n,
  input  wire logic              write_strobe_n,
  input  wire logic              out_enable_n,
  input  wire logic [ADDR_W-1:0] muxed_addr_pins,
  // Data wire
  input  wire logic [DATA_W-1:0] data_pins_out,
  input  wire logic              data_pins_oe_n,
  output logic      [DATA_W-1:0] dq_level,
  // Observations
  output int                     viol,
  output int                     ras_cycles,
  output int                     cas_cycles,
  output int                     refreshes,
  output int                     max_gap_ns
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam int ROW_HOLD_NS = 15;
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] cur, last;
  logic [ADDR_W-1:0] row_q;
  realtime           t_ras, t_cas, t_ref;
  bit                cbr, rd, wr, amb, hold_ok;
  wire               model_on = rd & ~amb & ~col_strobe_n & ~out_enable_n;

  initial begin
    {viol, ras_cycles, cas_cycles, refreshes, max_gap_ns} = '0;
    {cur, last, row_q, cbr, rd, wr, amb, hold_ok} = '0;
    t_ras = -1.0e6;
    t_cas = -1.0e6;
    t_ref = 0.0;
  end

  always @(negedge row_strobe_n) begin
    if (ras_cycles > 0 && $realtime - t_ras < RC_NS) viol++;
    t_ras = $realtime;
    ras_cycles++;
    row_q = muxed_addr_pins;
    cbr = !col_strobe_n;
    if (cbr && $realtime - t_cas < T_CSR_NS) viol++;
    if (cbr && refreshes > 0 && $realtime - t_ref > max_gap_ns)
      max_gap_ns = int'($realtime - t_ref);
    if (cbr) refreshes++;
    if (cbr) t_ref = $realtime;
  end

  always @(posedge row_strobe_n) begin
    if (ras_cycles > 0 && $realtime - t_ras > T_RAS_MAX_NS) viol++;
    if (rd && !hold_ok && !write_strobe_n) viol++;
    {rd, wr, amb} = '0;
  end

  always @(negedge col_strobe_n) begin
    t_cas = $realtime;
    if (!row_strobe_n) begin
      cas_cycles++;
      if ($realtime - t_ras < T_RCD_NS) viol++;
      wr = !write_strobe_n;
      // Early write never drives the pins
      rd = write_strobe_n;
      if (wr && data_pins_oe_n) viol++;
      if (wr) mem[{row_q, muxed_addr_pins}] = data_pins_out;
      cur = mem.exists({row_q, muxed_addr_pins}) ? mem[{row_q, muxed_addr_pins}] : '0;
    end
  end

  always @(posedge col_strobe_n) begin
    hold_ok = write_strobe_n;
    if (cbr && $realtime - t_cas < T_CHR_NS) viol++;
    cbr = 1'b0;
  end

  // Late write strobe leaves the output undefined
  always @(negedge write_strobe_n) if (!col_strobe_n && !row_strobe_n) amb = 1'b1;
  always @(muxed_addr_pins) if (!row_strobe_n && $realtime - t_ras < ROW_HOLD_NS) viol++;
  always @(data_pins_out, data_pins_oe_n) if (wr && $realtime - t_cas < T_DH_NS) viol++;
  always @(posedge model_on, negedge data_pins_oe_n) if (model_on && !data_pins_oe_n) viol++;
  always @(negedge model_on) last = cur;

  // Released wire shows the inverse, so a stale sample cannot pass
  always @* begin
    if (!data_pins_oe_n) dq_level = data_pins_out;
    else if (model_on) dq_level = cur;
    else dq_level = ~last;
  end
endmodule // adc_dram_model

// *** testbench/test_adc_host.sv ***
// Self-checking bench for the page-mode DRAM host sequencer
module test_adc_host
  import adc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int INIT_TB = 10;
  localparam int LIMIT   = 20000;
  // A refresh may wait out one access in flight
  localparam int GAP_NS  = REFRESH_STD_MS * 1000000 / ROW_COUNT + 10 * CLK_NS;
  logic                ref_clk, srst, req_valid, req_write, req_ready, rsp_valid, init_done;
  logic                row_strobe_n, col_strobe_n, write_strobe_n, out_enable_n, data_pins_oe_n;
  logic [2*ADDR_W-1:0] req_addr;
  logic [ADDR_W-1:0]   muxed_addr_pins;
  logic [DATA_W-1:0]   req_wdata, rsp_rdata, data_pins_out, data_pins_in;
  int                  viol, ras_cycles, cas_cycles, refreshes, max_gap_ns;
  int                  err_count = 0;
  int                  total_checks = 0;
  int                  cycles = 0;
  logic [17:0]         tab_a [5] = '{18'h00000, 18'h3FFFF, 18'h3FE00, 18'h001FF, 18'h2AA55};
  logic [3:0]          tab_d [5] = '{4'h5, 4'hA, 4'hF, 4'h0, 4'h3};

  adc_host #(.FAST_GRADE(1'b1), .LOW_POWER(1'b0), .INIT_CYCLES(INIT_TB)) dut (
    .ref_clk(ref_clk), .srst(srst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done),
    .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
    .write_strobe_n(write_strobe_n), .out_enable_n(out_enable_n),
    .muxed_addr_pins(muxed_addr_pins), .data_pins_out(data_pins_out),
    .data_pins_oe_n(data_pins_oe_n), .data_pins_in(data_pins_in));

  adc_dram_model #(.RC_NS(T_RC_F_NS)) mem (
    .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
    .write_strobe_n(write_strobe_n), .out_enable_n(out_enable_n),
    .muxed_addr_pins(muxed_addr_pins), .data_pins_out(data_pins_out),
    .data_pins_oe_n(data_pins_oe_n), .dq_level(data_pins_in), .viol(viol),
    .ras_cycles(ras_cycles), .cas_cycles(cas_cycles), .refreshes(refreshes),
    .max_gap_ns(max_gap_ns));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      $display("ERROR %0t: run did not finish", $time);
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // One request, sent for one cycle once ready is seen, then watched for eight cycles
  task automatic access(input logic wr, input logic [17:0] a, input logic [3:0] d);
    int n, first, highs;
    {n, first, highs} = '0;
    while (req_ready !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(req_ready, 1'b1, "ready");
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, wr, a, d};
    @(posedge ref_clk);
    #1;
    req_valid = 1'b0;
    check(req_ready, 1'b0, "busy after take");
    for (int k = 1; k <= 8; k++) begin
      @(posedge ref_clk);
      #1;
      if (rsp_valid === 1'b1) highs++;
      if (rsp_valid === 1'b1 && first == 0) first = k;
      if (k == 1) check(muxed_addr_pins, a[17:9], "row address at row strobe");
      if (k == 1) check({row_strobe_n, col_strobe_n}, 2'h1, "row strobe first");
      if (k == 3) check(col_strobe_n, 1'b0, "column strobe low");
      if (k == 3) check(muxed_addr_pins, a[8:0], "column address");
      if (k == 3) check(write_strobe_n, !wr, "write strobe at column");
      if (k == 3) check(data_pins_oe_n, !wr, "host data drive");
      if (k == 3) check(out_enable_n, wr, "output enable at column");
    end
    if (!wr) check(first, 4, "read answer cycle");
    check(highs, !wr, "answer pulses");
  endtask

  task automatic test_init();
    int n, r0, c0;
    n = 0;
    srst = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1;
    check({row_strobe_n, col_strobe_n, write_strobe_n, out_enable_n, data_pins_oe_n},
          5'h1F, "pins idle in reset");
    check({init_done, req_ready, rsp_valid}, 3'h0, "outputs in reset");
    {r0, c0} = {ras_cycles, cas_cycles};
    srst = 1'b0;
    while (init_done !== 1'b1 && n < 500) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(n > INIT_TB + WAKE_COUNT, 1'b1, "pause length");
    check(ras_cycles - r0, WAKE_COUNT, "wake cycles");
    check(cas_cycles - c0, 0, "access before wake");
    $display("test_init done");
  endtask

  task automatic test_rw();
    for (int i = 0; i < 5; i++) access(1'b1, tab_a[i], tab_d[i]);
    for (int i = 0; i < 5; i++) begin
      access(1'b0, tab_a[i], 4'h0);
      check(rsp_rdata, tab_d[i], "read back");
    end
    access(1'b1, tab_a[0], 4'hC);
    access(1'b0, tab_a[0], 4'h0);
    check(rsp_rdata, 4'hC, "overwrite");
    $display("test_rw done");
  endtask

  task automatic test_refresh();
    int r0;
    r0 = refreshes;
    for (int i = 0; i < 60; i++) begin
      access(1'b0, tab_a[i % 5], 4'h0);
      check(rsp_rdata, (i % 5 == 0) ? 4'hC : tab_d[i % 5], "read among refresh");
    end
    check(refreshes - r0 >= 3, 1'b1, "refresh count");
    check(max_gap_ns <= GAP_NS, 1'b1, "refresh spacing");
    $display("test_refresh done");
  endtask

  task automatic test_reset_mid();
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, 1'b1, 18'h12345, 4'h9};
    @(posedge ref_clk);
    #1;
    req_valid = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    test_init();
    access(1'b0, tab_a[1], 4'h0);
    check(rsp_rdata, tab_d[1], "read after reset");
    $display("test_reset_mid done");
  endtask

  initial begin
    {req_valid, req_write, req_addr, req_wdata} = '0;
    test_init();
    test_rw();
    test_refresh();
    test_reset_mid();
    check(viol, 0, "strobe timing");
    results();
  end
endmodule // test_adc_host
